// ===== core/sotp_pkg.sv
package sotp_pkg;
   localparam int SOTP_SPACE_BYTES = 1024;
   localparam int SOTP_REGION_BYTES = 32;
   localparam int SOTP_REGIONS = 32;
   localparam int SOTP_ADDR_W = 10;
   localparam int SOTP_SECT_W = 8;
   localparam int SOTP_OFS_W = 12;
   localparam logic [9:0] SOTP_RAND_LAST = 10'h00f;
   localparam logic [9:0] SOTP_LOCK_FIRST = 10'h010;
   localparam logic [9:0] SOTP_LOCK_LAST = 10'h013;
   localparam logic [9:0] SOTP_RSVD_LAST = 10'h01f;
   localparam logic [7:0] SOTP_ERASED = 8'hff;
   localparam int SOTP_FREEZE_BIT = 10;
   localparam int SOTP_PGM_ERR_BIT = 4;
   localparam int SOTP_READY_BIT = 7;
   localparam logic [3:0] SOTP_PGM_CYCLES = 4'h4;
   typedef enum logic [2:0] {
      SOTP_CMD_NONE,
      SOTP_CMD_ENTRY,
      SOTP_CMD_EXIT,
      SOTP_CMD_PROGRAM,
      SOTP_CMD_ERASE
   } sotp_cmd_t;
endpackage

// ===== core/sotp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sotp_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   if (W < 1) begin
      $error("sync width must be at least one");
   end
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sotp_sync_t;
   sotp_sync_t r;
   sotp_sync_t next_r;
   always_comb begin
      next_r.s1 = d_in;
      next_r.s2 = r.s1;
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q_out = r.s2;
endmodule
`default_nettype wire

// ===== core/sotp_link.sv
`timescale 1ns/1ps
`default_nettype none
// link-clock side: captures a command word, flags it by toggle
module sotp_link
   import sotp_pkg::*;
(
   input wire logic link_clk_in,
   input wire logic link_rst_in,
   input wire logic cmd_valid_in,
   input wire sotp_cmd_t cmd_in,
   input wire logic [SOTP_SECT_W-1:0] sect_in,
   input wire logic [SOTP_OFS_W-1:0] ofs_in,
   input wire logic [7:0] data_in,
   output logic tgl_out,
   output sotp_cmd_t cmd_out,
   output logic [SOTP_SECT_W-1:0] sect_out,
   output logic [SOTP_OFS_W-1:0] ofs_out,
   output logic [7:0] data_out
);
   typedef struct packed {
      logic tgl;
      sotp_cmd_t cmd;
      logic [SOTP_SECT_W-1:0] sect;
      logic [SOTP_OFS_W-1:0] ofs;
      logic [7:0] data;
   } sotp_link_t;
   sotp_link_t r;
   sotp_link_t next_r;
   always_comb begin
      next_r = r;
      if (cmd_valid_in && cmd_in != SOTP_CMD_NONE) begin
         next_r.tgl = ~r.tgl;
         next_r.cmd = cmd_in;
         next_r.sect = sect_in;
         next_r.ofs = ofs_in;
         next_r.data = data_in;
      end
   end
   always_ff @(posedge link_clk_in) begin
      if (link_rst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign tgl_out = r.tgl;
   assign cmd_out = r.cmd;
   assign sect_out = r.sect;
   assign ofs_out = r.ofs;
   assign data_out = r.data;
endmodule
`default_nettype wire

// ===== core/sotp_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 1024 bytes, 32 aligned regions of 32
// - factory bytes 0..15 never program; data other than ff flags error
// - bytes 0x10..0x13 hold one lock per region
// - reserved bytes 0x14..0x1f stay host programmable
// - regions 1..31 erased, free for user data
// - all non-factory bytes start erased at ff
// - freeze bit zero blocks all programming
// - frozen program only clears the error flag
// - entry names sector; overlay covers that sector
// - overlay reads past valid range are undefined
// - other sectors still read the main array
// - exit ends the overlay
// - program only clears bits; erase never happens
// - program ignores address bit ten and above
// - overlay, freeze, locks and the factory range guard the space
module sotp_core
   import sotp_pkg::*;
#(
   parameter logic [127:0] FACTORY_RANDOM = 128'h0123456789abcdef_fedcba9876543210
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic link_clk_in,
   input wire logic link_rst_in,
   input wire logic cmd_valid_in,
   input wire sotp_cmd_t cmd_in,
   input wire logic [SOTP_SECT_W-1:0] cmd_sect_in,
   input wire logic [SOTP_OFS_W-1:0] cmd_ofs_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic [15:0] config_reg_volatile_or_nv_in,
   input wire logic rd_req_in,
   input wire logic [SOTP_SECT_W-1:0] rd_sect_in,
   input wire logic [SOTP_OFS_W-1:0] rd_ofs_in,
   input wire logic [7:0] array_rd_data_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic rd_from_array_out,
   output logic address_space_overlay_out,
   output logic [SOTP_SECT_W-1:0] overlay_sect_out,
   output logic busy_out,
   output logic [7:0] flash_status_reg_out,
   output logic [SOTP_REGIONS-1:0] region_lock_out
);
   if (SOTP_REGIONS * SOTP_REGION_BYTES != SOTP_SPACE_BYTES) begin
      $error("space must be regions times region size");
   end

   logic l_tgl;
   sotp_cmd_t l_cmd;
   logic [SOTP_SECT_W-1:0] l_sect;
   logic [SOTP_OFS_W-1:0] l_ofs;
   logic [7:0] l_data;
   logic tgl_s;
   logic [15:0] cfg_s;

   sotp_link u_link (
      .link_clk_in(link_clk_in),
      .link_rst_in(link_rst_in),
      .cmd_valid_in(cmd_valid_in),
      .cmd_in(cmd_in),
      .sect_in(cmd_sect_in),
      .ofs_in(cmd_ofs_in),
      .data_in(cmd_data_in),
      .tgl_out(l_tgl),
      .cmd_out(l_cmd),
      .sect_out(l_sect),
      .ofs_out(l_ofs),
      .data_out(l_data)
   );

   // toggle crosses; payload is held stable until the next toggle
   sotp_sync #(.W(1)) u_tsync (
      .clk_in(mclk_in),
      .rst_in(sys_rst_in),
      .d_in(l_tgl),
      .q_out(tgl_s)
   );

   sotp_sync #(.W(16)) u_csync (
      .clk_in(mclk_in),
      .rst_in(sys_rst_in),
      .d_in(config_reg_volatile_or_nv_in),
      .q_out(cfg_s)
   );

   // nonvolatile bytes: reset never touches them, like real otp cells
   logic [7:0] mem [SOTP_SPACE_BYTES];
   // starts clear so the fill runs once; later resets keep the bytes
   logic mem_init = 1'b0;
   logic [SOTP_ADDR_W-1:0] init_ptr;

   typedef struct packed {
      logic tgl_seen;
      logic overlay;
      logic [SOTP_SECT_W-1:0] sect;
      logic busy;
      logic [3:0] cnt;
      logic do_wr;
      logic [SOTP_ADDR_W-1:0] wa;
      logic [7:0] wd;
      logic pgm_err;
      logic [7:0] rd_data;
      logic rd_valid;
      logic rd_arr;
   } sotp_core_t;
   sotp_core_t r;
   sotp_core_t next_r;

   logic [SOTP_ADDR_W-1:0] pa;
   logic [SOTP_ADDR_W-1:0] ra;
   logic [4:0] preg;
   logic lock_ok;
   logic frozen;
   logic [SOTP_REGIONS-1:0] locks;
   logic cmd_new;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         locks[i*8 +: 8] = mem[SOTP_LOCK_FIRST + 10'(i)];
      end
   end

   assign cmd_new = tgl_s != r.tgl_seen;
   assign pa = l_ofs[SOTP_ADDR_W-1:0];
   assign preg = pa[9:5];
   assign lock_ok = locks[preg];
   assign frozen = ~cfg_s[SOTP_FREEZE_BIT];
   assign ra = rd_ofs_in[SOTP_ADDR_W-1:0];

   always_comb begin
      next_r = r;
      next_r.do_wr = 1'b0;
      next_r.rd_valid = rd_req_in;
      next_r.tgl_seen = tgl_s;
      if (cmd_new && !r.busy) begin
         unique case (l_cmd)
            SOTP_CMD_ENTRY: begin
               next_r.overlay = 1'b1;
               next_r.sect = l_sect;
            end
            SOTP_CMD_EXIT: begin
               next_r.overlay = 1'b0;
            end
            SOTP_CMD_PROGRAM: begin
               next_r.pgm_err = 1'b0;
               if (!r.overlay || frozen) begin
                  next_r.pgm_err = 1'b0;
               end else if (pa <= SOTP_RAND_LAST) begin
                  next_r.pgm_err = (l_data != SOTP_ERASED);
               end else if (lock_ok) begin
                  // reserved and user bytes program alike
                  next_r.busy = 1'b1;
                  next_r.cnt = SOTP_PGM_CYCLES;
                  next_r.wa = pa;
                  next_r.wd = mem[pa] & l_data;
               end
            end
            default: begin
               // erase and anything else are dropped
               next_r.busy = r.busy;
            end
         endcase
      end else if (cmd_new) begin
         next_r.tgl_seen = r.tgl_seen;
      end
      if (r.busy) begin
         next_r.cnt = r.cnt - 4'h1;
         if (r.cnt == 4'h1) begin
            next_r.busy = 1'b0;
            next_r.do_wr = 1'b1;
         end
      end
      next_r.rd_arr = !(r.overlay && rd_sect_in == r.sect);
      if (r.overlay && rd_sect_in == r.sect) begin
         // past the space: mirror wraps, value is undefined anyway
         next_r.rd_data = mem[ra];
      end else begin
         next_r.rd_data = array_rd_data_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // one-time fill of the delivery image after first reset
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in && !mem_init) begin
         init_ptr <= '0;
      end else if (!mem_init) begin
         if (init_ptr <= SOTP_RAND_LAST) begin
            mem[init_ptr] <= FACTORY_RANDOM[init_ptr[3:0]*8 +: 8];
         end else begin
            mem[init_ptr] <= SOTP_ERASED;
         end
         init_ptr <= init_ptr + 10'h1;
         if (init_ptr == 10'(SOTP_SPACE_BYTES - 1)) begin
            mem_init <= 1'b1;
         end
      end else if (r.do_wr) begin
         mem[r.wa] <= r.wd;
      end
   end
   assign rd_data_out = r.rd_data;
   assign rd_valid_out = r.rd_valid;
   assign rd_from_array_out = r.rd_arr;
   assign address_space_overlay_out = r.overlay;
   assign overlay_sect_out = r.sect;
   assign busy_out = r.busy | ~mem_init;
   always_comb begin
      flash_status_reg_out = 8'h00;
      flash_status_reg_out[SOTP_PGM_ERR_BIT] = r.pgm_err;
      flash_status_reg_out[SOTP_READY_BIT] = ~(r.busy | ~mem_init);
   end
   assign region_lock_out = locks;
endmodule
`default_nettype wire

// ===== dv/sotp_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sotp_core_properties
   import sotp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [15:0] config_reg_volatile_or_nv_in,
   input wire logic rd_req_in,
   input wire logic [SOTP_SECT_W-1:0] rd_sect_in,
   input wire logic [7:0] array_rd_data_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire logic rd_from_array_out,
   input wire logic address_space_overlay_out,
   input wire logic [SOTP_SECT_W-1:0] overlay_sect_out,
   input wire logic busy_out,
   input wire logic [7:0] flash_status_reg_out,
   input wire logic [SOTP_REGIONS-1:0] region_lock_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   sequence rd_ovl;
      rd_req_in && address_space_overlay_out;
   endsequence
   // eight cycles covers the two-flop sync plus a command in flight
   sequence frozen;
      !config_reg_volatile_or_nv_in[SOTP_FREEZE_BIT] [*8];
   endsequence
   AST_RD_VALID: assert property (rd_req_in |=> rd_valid_out)
      else $error("read not answered");
   AST_ARRAY: assert property (rd_req_in && !address_space_overlay_out |=>
      rd_from_array_out && rd_data_out == $past(array_rd_data_in)) else $error("array read");
   AST_OTHER: assert property (rd_ovl ##0 rd_sect_in != overlay_sect_out |=>
      rd_from_array_out) else $error("other sector");
   AST_OVERLAY: assert property (rd_ovl ##0 rd_sect_in == overlay_sect_out |=>
      !rd_from_array_out) else $error("overlay sector");
   AST_LOCK: assert property (!busy_out && !$past(busy_out) |->
      (region_lock_out & ~$past(region_lock_out)) == '0) else $error("lock reopened");
   AST_FRZ_LOCK: assert property (frozen |=> $stable(region_lock_out))
      else $error("frozen lock change");
   AST_FRZ_ERR: assert property (frozen |=> !$rose(flash_status_reg_out[SOTP_PGM_ERR_BIT]))
      else $error("frozen error flag");
   AST_BUSY: assert property ($rose(busy_out) && !$past(sys_rst_in) |-> ##[1:8] !busy_out)
      else $error("program too long");
endmodule
bind sotp_core sotp_core_properties chk (.*);
`default_nettype wire

// ===== dv/sotp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sotp_host
   import sotp_pkg::*;
(
   input wire logic link_clk_in,
   output logic cmd_valid_out,
   output sotp_cmd_t cmd_out,
   output logic [SOTP_SECT_W-1:0] sect_out,
   output logic [SOTP_OFS_W-1:0] ofs_out,
   output logic [7:0] data_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = SOTP_CMD_NONE;
      sect_out = 8'h00;
      ofs_out = 12'h000;
      data_out = 8'h00;
   end
   // one link cycle per command; released sect, ofs and data inverted, cmd set to none, never left valid
   task automatic send(input sotp_cmd_t c, input logic [11:0] o, input logic [7:0] d);
      @(posedge link_clk_in);
      #1;
      cmd_valid_out = 1'b1;
      cmd_out = c;
      sect_out = o[7:0];
      ofs_out = o;
      data_out = d;
      @(posedge link_clk_in);
      #1;
      cmd_valid_out = 1'b0;
      cmd_out = SOTP_CMD_NONE;
      sect_out = ~o[7:0];
      ofs_out = ~o;
      data_out = ~d;
   endtask
endmodule
`default_nettype wire

// ===== dv/sotp_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sotp_core_bench
   import sotp_pkg::*;
;
   localparam logic [127:0] RND = 128'h00112233445566778899aabbccddeeff; // arbitrary
   logic mclk_in, sys_rst_in, link_clk_in, link_rst_in, cmd_valid_in, rd_req_in;
   logic rd_valid_out, rd_from_array_out, address_space_overlay_out, busy_out;
   sotp_cmd_t cmd_in;
   logic [7:0] cmd_sect_in, rd_sect_in, overlay_sect_out, cmd_data_in, rd_data_out;
   logic [7:0] array_rd_data_in, flash_status_reg_out;
   logic [11:0] cmd_ofs_in, rd_ofs_in;
   logic [15:0] config_reg_volatile_or_nv_in;
   logic [31:0] region_lock_out;
   int num_errors, n_tests;
   assign array_rd_data_in = rd_ofs_in[7:0] ^ 8'h5a;
   sotp_core #(.FACTORY_RANDOM(RND)) dut (.*);
   sotp_host host (.link_clk_in(link_clk_in), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in),
      .sect_out(cmd_sect_in), .ofs_out(cmd_ofs_in), .data_out(cmd_data_in));
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #7;
      forever #24 link_clk_in = ~link_clk_in;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmd(input sotp_cmd_t c, input logic [11:0] o, input logic [7:0] d);
      host.send(c, o, d);
      repeat (20) @(posedge mclk_in);
      #1;
   endtask
   // e is {valid, from array, data}
   task automatic rd(input logic [7:0] s, input logic [11:0] o, input logic [9:0] e);
      @(posedge mclk_in);
      #1;
      rd_req_in = 1'b1;
      rd_sect_in = s;
      rd_ofs_in = o;
      @(posedge mclk_in);
      #1;
      rd_req_in = 1'b0;
      chk("read", {rd_valid_out, rd_from_array_out, rd_data_out}, e);
   endtask
   task automatic t_map();
      cmd(SOTP_CMD_ENTRY, 12'h003, 8'h00);
      chk("overlay", {address_space_overlay_out, overlay_sect_out}, 9'h103);
      for (int i = 0; i < 16; i++) begin
         rd(8'h03, 12'(i), {2'b10, RND[8*i+:8]});
      end
      for (int i = 16; i < 1024; i++) begin
         rd(8'h03, 12'(i), 10'h2ff);
      end
      rd(8'h04, 12'h025, 10'h37f);
   endtask
   task automatic t_prog();
      cmd(SOTP_CMD_PROGRAM, 12'h025, 8'h0f);
      cmd(SOTP_CMD_PROGRAM, 12'h025, 8'hf3);
      rd(8'h03, 12'h025, 10'h203);
      cmd(SOTP_CMD_PROGRAM, 12'hc25, 8'hfe);
      rd(8'h03, 12'h025, 10'h202);
      cmd(SOTP_CMD_ERASE, 12'h025, 8'hff);
      rd(8'h03, 12'h025, 10'h202);
      cmd(SOTP_CMD_PROGRAM, 12'h01f, 8'h00);
      rd(8'h03, 12'h01f, 10'h200);
      cmd(SOTP_CMD_PROGRAM, 12'h000, 8'h00);
      chk("error", flash_status_reg_out[SOTP_PGM_ERR_BIT], 1'b1);
      rd(8'h03, 12'h000, {2'b10, RND[7:0]});
   endtask
   task automatic t_lock();
      cmd(SOTP_CMD_PROGRAM, 12'h010, 8'hfd);
      cmd(SOTP_CMD_PROGRAM, 12'h013, 8'h7f);
      chk("lock", region_lock_out, 32'h7ffffffd);
      cmd(SOTP_CMD_PROGRAM, 12'h030, 8'h00);
      rd(8'h03, 12'h030, 10'h2ff);
   endtask
   task automatic t_freeze();
      @(posedge mclk_in);
      #1;
      config_reg_volatile_or_nv_in[SOTP_FREEZE_BIT] = 1'b0;
      repeat (4) @(posedge mclk_in);
      cmd(SOTP_CMD_PROGRAM, 12'h040, 8'h00);
      rd(8'h03, 12'h040, 10'h2ff);
      cmd(SOTP_CMD_PROGRAM, 12'h011, 8'h00);
      chk("lock", region_lock_out, 32'h7ffffffd);
      cmd(SOTP_CMD_PROGRAM, 12'h000, 8'h00);
      chk("error", flash_status_reg_out[SOTP_PGM_ERR_BIT], 1'b0);
   endtask
   task automatic t_exit();
      cmd(SOTP_CMD_EXIT, 12'h000, 8'h00);
      chk("overlay", address_space_overlay_out, 1'b0);
      rd(8'h03, 12'h040, 10'h31a);
   endtask
   initial begin
      num_errors = 0;
      n_tests = 0;
      sys_rst_in = 1'b1;
      link_rst_in = 1'b1;
      rd_req_in = 1'b0;
      rd_sect_in = 8'h00;
      rd_ofs_in = 12'h000;
      config_reg_volatile_or_nv_in = 16'hffff;
      repeat (8) @(posedge mclk_in);
      #1;
      sys_rst_in = 1'b0;
      link_rst_in = 1'b0;
      for (int i = 0; i < 1100 && busy_out !== 1'b0; i++) @(posedge mclk_in);
      #1;
      chk("busy", busy_out, 1'b0);
      chk("status", flash_status_reg_out, 32'h1 << SOTP_READY_BIT);
      t_map();
      t_prog();
      t_lock();
      t_freeze();
      t_exit();
      conclude();
   end
   initial begin
      #400000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
